// file: tkx_pkg.sv
package tkx_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CONN = 8'h00;
   localparam logic [7:0] OFF_REQ = 8'h04;
   localparam logic [7:0] OFF_CONFIRM = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_WRAP = 8'h10;

   // request register layout
   localparam int REQ_B1_LSB = 8;
   localparam int REQ_TYPE_LSB = 16;
   localparam int CONFIRM_BIT = 0;
   typedef enum logic [1:0] {
      MSG_NONE = 2'h0,
      MSG_MAIN = 2'h1,
      MSG_QUICK = 2'h2,
      MSG_EXPL = 2'h3
   } tkx_msg_e;

   // request flag positions
   localparam int FL_FIRST = 3;
   localparam int FL_RENEW = 2;
   localparam int FL_BUMP = 1;
   localparam int FL_SLOT = 0;
   localparam int KEY_IDX_LSB = 2;

   // response header: four zero bytes, flags byte, counter byte
   localparam logic [7:0] HEAD_BYTES = 8'h06;
   localparam logic [7:0] FLAGS_POS = 8'h04;
   localparam logic [7:0] COUNT_POS = 8'h05;
   localparam logic [7:0] RST_COUNTER = 8'h00;

   // status register bit positions
   localparam int SB_BUSY = 0;
   localparam int SB_PEND = 1;
   localparam int SB_COOKIE = 2;
   localparam int SB_CSEQ = 3;
   localparam int SB_CNT_LSB = 4;
   localparam int SB_SLOT = 12;
   localparam int SB_IDX_LSB = 13;
   localparam int SB_FIRST = 19;
   localparam int SB_RSV_ERR = 20;
   localparam int SB_DROP = 21;
   localparam int SB_CONN_ERR = 22;
   localparam int SB_READY = 23;

   // wrapped key register
   localparam int WR_CTR = 0;
   localparam int WR_OFF_LSB = 8;

   // response sequencer states
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_HEAD = 5'b00010,
      ST_NONCE = 5'b00100,
      ST_AUTH = 5'b01000,
      ST_PUB = 5'b10000
   } tkx_state_e;
endpackage

// file: tkx_if.sv
`timescale 1ns/1ps
// key state updates between the sequencer and the keeper
interface tkx_keep_if;
   logic upd;
   logic renew;
   logic bump;
   logic confirm;
   logic ready;
   logic pend;
   logic cookie_seq;
   logic counter_seq;
   logic [7:0] counter;
   modport ctl (output upd, renew, bump, confirm,
                input ready, pend, cookie_seq, counter_seq, counter);
   modport keep (input upd, renew, bump, confirm,
                 output ready, pend, cookie_seq, counter_seq, counter);
endinterface

// response bytes towards the bit serialiser
interface tkx_byte_if;
   logic valid;
   logic ready;
   logic last;
   logic [7:0] data;
   modport src (output valid, last, data, input ready);
   modport snk (input valid, last, data, output ready);
endinterface

// file: tkx_keeper.sv
`timescale 1ns/1ps
module tkx_keeper (
   input wire logic pclk,
   input wire logic presetn,
   tkx_keep_if.keep k,
   input wire logic nv_cookie_seq,
   input wire logic nv_counter_seq,
   input wire logic [7:0] nv_counter,
   output logic commit_strobe,
   output logic commit_cookie_seq,
   output logic commit_counter_seq,
   output logic [7:0] commit_counter,
   output logic cookie_gen,
   output logic cookie_commit
);
   logic loaded;
   logic pend, p_cs, p_ns, p_renew;
   logic [7:0] p_cnt;
   logic base_cs, base_ns;
   logic [7:0] base_cnt;

   // successive exchanges build on the pending values until confirmed
   assign base_cs = pend ? p_cs : commit_cookie_seq;
   assign base_ns = pend ? p_ns : commit_counter_seq;
   assign base_cnt = pend ? p_cnt : commit_counter;
   assign k.ready = loaded;
   assign k.pend = pend;
   assign k.cookie_seq = base_cs;
   assign k.counter_seq = base_ns;
   assign k.counter = base_cnt;

   // committed copy: straps are caught on the first edge after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded <= 1'b0;
         commit_cookie_seq <= 1'b0;
         commit_counter_seq <= 1'b0;
         commit_counter <= tkx_pkg::RST_COUNTER;
         commit_strobe <= 1'b0;
         cookie_commit <= 1'b0;
      end else begin
         loaded <= 1'b1;
         commit_strobe <= loaded & k.confirm & pend;
         cookie_commit <= loaded & k.confirm & pend & p_renew;
         if (!loaded) begin
            commit_cookie_seq <= nv_cookie_seq;
            commit_counter_seq <= nv_counter_seq;
            commit_counter <= nv_counter;
         end else if (k.confirm && pend) begin
            commit_cookie_seq <= p_cs;
            commit_counter_seq <= p_ns;
            commit_counter <= p_cnt;
         end
      end
   end

   // pending copy; a reset throws away anything unconfirmed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 1'b0;
         p_cs <= 1'b0;
         p_ns <= 1'b0;
         p_renew <= 1'b0;
         p_cnt <= tkx_pkg::RST_COUNTER;
         cookie_gen <= 1'b0;
      end else begin
         cookie_gen <= k.upd & k.renew;
         if (k.confirm) begin
            pend <= 1'b0;
            p_renew <= 1'b0;
         end else if (k.upd && k.renew) begin
            pend <= 1'b1;
            p_renew <= 1'b1;
            p_cs <= ~base_cs;
            p_cnt <= tkx_pkg::RST_COUNTER;
            p_ns <= 1'b0;
         end else if (k.upd && k.bump) begin
            pend <= 1'b1;
            p_renew <= p_renew & pend;
            p_cs <= base_cs;
            p_cnt <= base_cnt + 8'h01;
            p_ns <= ~base_ns;
         end
      end
   end
endmodule

// file: tkx_bit_ser.sv
`timescale 1ns/1ps
module tkx_bit_ser (
   input wire logic pclk,
   input wire logic presetn,
   tkx_byte_if.snk b,
   input wire logic tx_ready,
   output logic tx_bit,
   output logic tx_valid,
   output logic tx_last
);
   logic [7:0] sh;
   logic [2:0] n;
   logic lst;

   // one byte at a time, so a stalled link stalls the sequencer
   assign b.ready = ~tx_valid;
   assign tx_bit = sh[7];

   // shift out bit 7 first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sh <= 8'h00;
         n <= 3'h0;
         lst <= 1'b0;
         tx_valid <= 1'b0;
         tx_last <= 1'b0;
      end else if (b.valid && !tx_valid) begin
         sh <= b.data;
         n <= 3'h7;
         lst <= b.last;
         tx_valid <= 1'b1;
         tx_last <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         sh <= {sh[6:0], 1'b0};
         n <= n - 3'h1;
         tx_valid <= (n != 3'h0);
         tx_last <= lst & (n == 3'h1);
      end
   end
endmodule

// file: tkx_handler.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
module tkx_handler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] nonce_len,
   input wire logic [7:0] auth_len,
   input wire logic [7:0] public_value_len,
   input wire logic nv_cookie_seq,
   input wire logic nv_counter_seq,
   input wire logic [7:0] nv_counter,
   output logic commit_strobe,
   output logic commit_cookie_seq,
   output logic commit_counter_seq,
   output logic [7:0] commit_counter,
   output logic cookie_gen,
   output logic cookie_commit,
   output logic key_update,
   output logic key_slot,
   output logic [5:0] key_index,
   output logic key_wrapped,
   output logic [2:0] fld_sel,
   output logic [7:0] fld_pos,
   input wire logic [7:0] fld_data,
   output logic tx_bit,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready
);
   tkx_keep_if kif ();
   tkx_byte_if bif ();

   logic [31:0] conn_q;
   tkx_pkg::tkx_msg_e msg_q;
   logic [15:0] req_q;
   logic [7:0] nl_q, al_q, pl_q;
   tkx_pkg::tkx_state_e state;
   logic [7:0] cnt;
   logic bv, bl;
   logic [7:0] bd;
   logic ctr_mode, first_q, rsv_err, drop_err;
   logic upd_q, renew_q, bump_q, confirm_q;
   logic [31:0] status_w;

   tkx_keeper u_keep (
      .pclk(pclk),
      .presetn(presetn),
      .k(kif.keep),
      .nv_cookie_seq(nv_cookie_seq),
      .nv_counter_seq(nv_counter_seq),
      .nv_counter(nv_counter),
      .commit_strobe(commit_strobe),
      .commit_cookie_seq(commit_cookie_seq),
      .commit_counter_seq(commit_counter_seq),
      .commit_counter(commit_counter),
      .cookie_gen(cookie_gen),
      .cookie_commit(cookie_commit)
   );

   tkx_bit_ser u_ser (
      .pclk(pclk),
      .presetn(presetn),
      .b(bif.snk),
      .tx_ready(tx_ready),
      .tx_bit(tx_bit),
      .tx_valid(tx_valid),
      .tx_last(tx_last)
   );

   // bus phases and address decode
   wire logic setup_ph = psel & ~penable;
   wire logic wr = psel & penable & pready & pwrite;
   wire logic hit_conn = (paddr == tkx_pkg::OFF_CONN);
   wire logic hit_req = (paddr == tkx_pkg::OFF_REQ);
   wire logic hit_conf = (paddr == tkx_pkg::OFF_CONFIRM);
   wire logic hit_stat = (paddr == tkx_pkg::OFF_STATUS);
   wire logic hit_wrap = (paddr == tkx_pkg::OFF_WRAP);
   wire logic mapped = hit_conn | hit_req | hit_conf | hit_stat | hit_wrap;

   // request word decode; the explicit request puts the key index ahead of the flags
   wire logic [1:0] w_type = pwdata[tkx_pkg::REQ_TYPE_LSB +: 2];
   wire logic [7:0] w_b0 = pwdata[7:0];
   wire logic [7:0] w_b1 = pwdata[tkx_pkg::REQ_B1_LSB +: 8];
   wire logic w_main = (w_type == tkx_pkg::MSG_MAIN);
   wire logic w_quick = (w_type == tkx_pkg::MSG_QUICK);
   wire logic w_expl = (w_type == tkx_pkg::MSG_EXPL);
   wire logic [7:0] w_flags = w_expl ? w_b1 : w_b0;
   wire logic w_renew = w_main & w_flags[tkx_pkg::FL_RENEW];
   wire logic w_bump = w_flags[tkx_pkg::FL_BUMP];
   wire logic w_first = w_main & w_flags[tkx_pkg::FL_FIRST];
   wire logic w_rsv_main = w_main & (|w_flags[7:4]);
   wire logic w_rsv_rest = ~w_main & (|w_flags[7:2]);
   wire logic w_rsv_byte = w_quick & (|w_b1);
   wire logic w_rsv = w_rsv_main | w_rsv_rest | w_rsv_byte;

   // a new request is only taken once the previous response has fully left
   wire logic idle_all = (state == tkx_pkg::ST_IDLE) & ~bv & ~tx_valid;
   wire logic req_wr = wr & hit_req;
   wire logic start = req_wr & (w_type != tkx_pkg::MSG_NONE) & idle_all & kif.ready;
   wire logic clr_rsv = wr & hit_stat & pwdata[tkx_pkg::SB_RSV_ERR];
   wire logic clr_drop = wr & hit_stat & pwdata[tkx_pkg::SB_DROP];

   // counter-mode keys carry both direction nonces ahead of the key itself
   wire logic [8:0] key_off = ctr_mode ? {nonce_len, 1'b0} : 9'h000;

   // response sequencing helpers
   wire logic has_pub = (msg_q == tkx_pkg::MSG_MAIN);
   wire logic [7:0] cur_len = (state == tkx_pkg::ST_HEAD) ? tkx_pkg::HEAD_BYTES :
                              (state == tkx_pkg::ST_NONCE) ? nl_q :
                              (state == tkx_pkg::ST_AUTH) ? al_q : pl_q;
   wire logic at_end = (cnt == cur_len - 8'h01);
   wire logic adv = (state != tkx_pkg::ST_IDLE) & (~bv | bif.ready);
   wire logic [5:0] idx_field = (msg_q == tkx_pkg::MSG_EXPL) ? key_index : 6'h00;
   wire logic [7:0] flags_rsp = {idx_field, kif.cookie_seq, kif.counter_seq};
   wire logic [7:0] head_byte = (cnt == tkx_pkg::FLAGS_POS) ? flags_rsp :
                                (cnt == tkx_pkg::COUNT_POS) ? kif.counter :
                                8'h00;
   wire logic [7:0] byte_mux = (state == tkx_pkg::ST_HEAD) ? head_byte : fld_data;

   // field order after the header, skipping fields of zero length
   function automatic tkx_pkg::tkx_state_e after_field(input tkx_pkg::tkx_state_e st,
         input logic [7:0] n, input logic [7:0] a, input logic [7:0] p, input logic pub);
      tkx_pkg::tkx_state_e r;
      r = tkx_pkg::ST_IDLE;
      if (pub && p != 8'h00 && st != tkx_pkg::ST_PUB)
         r = tkx_pkg::ST_PUB;
      if (a != 8'h00 && (st == tkx_pkg::ST_HEAD || st == tkx_pkg::ST_NONCE))
         r = tkx_pkg::ST_AUTH;
      if (n != 8'h00 && st == tkx_pkg::ST_HEAD)
         r = tkx_pkg::ST_NONCE;
      return r;
   endfunction

   wire tkx_pkg::tkx_state_e nxt_field = after_field(state, nl_q, al_q, pl_q, has_pub);
   wire tkx_pkg::tkx_state_e next_state = at_end ? nxt_field : state;

   assign kif.upd = upd_q;
   assign kif.renew = renew_q;
   assign kif.bump = bump_q;
   assign kif.confirm = confirm_q;
   assign bif.valid = bv;
   assign bif.data = bd;
   assign bif.last = bl;
   // one-hot state bits go out as they are, so the field select leaves a flop directly
   assign fld_sel = {state[4], state[3], state[2]};
   assign fld_pos = cnt;

   // status word assembly
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[tkx_pkg::SB_BUSY] = ~idle_all;
      status_w[tkx_pkg::SB_PEND] = kif.pend;
      status_w[tkx_pkg::SB_COOKIE] = kif.cookie_seq;
      status_w[tkx_pkg::SB_CSEQ] = kif.counter_seq;
      status_w[tkx_pkg::SB_CNT_LSB +: 8] = kif.counter;
      status_w[tkx_pkg::SB_SLOT] = key_slot;
      status_w[tkx_pkg::SB_IDX_LSB +: 6] = key_index;
      status_w[tkx_pkg::SB_FIRST] = first_q;
      status_w[tkx_pkg::SB_RSV_ERR] = rsv_err;
      status_w[tkx_pkg::SB_DROP] = drop_err;
      status_w[tkx_pkg::SB_CONN_ERR] = |conn_q;
      status_w[tkx_pkg::SB_READY] = kif.ready;
   end

   wire logic [31:0] wrap_w = {15'h0000, key_off, 7'h00, ctr_mode};
   wire logic [31:0] req_w = {14'h0000, msg_q, req_q};
   wire logic [31:0] rd_mux = hit_conn ? conn_q : hit_req ? req_w :
                              hit_stat ? status_w : hit_wrap ? wrap_w : 32'h0000_0000;

   // no wait state: the answer is registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_ph;
         pslverr <= setup_ph & ~mapped;
         prdata <= (setup_ph & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // plain configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conn_q <= 32'h0000_0000;
         ctr_mode <= 1'b0;
      end else begin
         if (wr && hit_conn)
            conn_q <= pwdata;
         if (wr && hit_wrap)
            ctr_mode <= pwdata[tkx_pkg::WR_CTR];
      end
   end

   // request capture; lengths are frozen so a change mid-response is harmless
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_q <= tkx_pkg::MSG_NONE;
         req_q <= 16'h0000;
         nl_q <= 8'h00;
         al_q <= 8'h00;
         pl_q <= 8'h00;
         first_q <= 1'b0;
      end else if (start) begin
         msg_q <= tkx_pkg::tkx_msg_e'(w_type);
         req_q <= pwdata[15:0];
         nl_q <= nonce_len;
         al_q <= auth_len;
         pl_q <= public_value_len;
         first_q <= w_first;
      end
   end

   // key state update and key install strobes, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upd_q <= 1'b0;
         renew_q <= 1'b0;
         bump_q <= 1'b0;
         confirm_q <= 1'b0;
         key_update <= 1'b0;
         key_slot <= 1'b0;
         key_index <= 6'h00;
         key_wrapped <= 1'b0;
      end else begin
         upd_q <= start & (w_renew | w_bump);
         renew_q <= start & w_renew;
         bump_q <= start & w_bump;
         confirm_q <= wr & hit_conf & pwdata[tkx_pkg::CONFIRM_BIT];
         key_update <= start;
         if (start) begin
            key_slot <= w_flags[tkx_pkg::FL_SLOT];
            key_wrapped <= w_expl;
            if (w_expl)
               key_index <= w_b0[tkx_pkg::KEY_IDX_LSB +: 6];
         end
      end
   end

   // sticky error flags; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsv_err <= 1'b0;
         drop_err <= 1'b0;
      end else begin
         rsv_err <= (start & w_rsv) | (rsv_err & ~clr_rsv);
         drop_err <= (req_wr & ~start) | (drop_err & ~clr_drop);
      end
   end

   // response sequencer walks header, nonce, authenticator, public value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= tkx_pkg::ST_IDLE;
         cnt <= 8'h00;
      end else if (start) begin
         state <= tkx_pkg::ST_HEAD;
         cnt <= 8'h00;
      end else if (adv) begin
         state <= next_state;
         cnt <= at_end ? 8'h00 : cnt + 8'h01;
      end
   end

   // byte holding stage in front of the serialiser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bv <= 1'b0;
         bd <= 8'h00;
         bl <= 1'b0;
      end else if (adv) begin
         bv <= 1'b1;
         bd <= byte_mux;
         bl <= at_end & (nxt_field == tkx_pkg::ST_IDLE);
      end else if (bif.ready) begin
         bv <= 1'b0;
      end
   end
endmodule

// file: tkx_handler_asserts.sv
`timescale 1ns/1ps
module tkx_handler_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic commit_strobe,
   input wire logic cookie_commit,
   input wire logic key_update,
   input wire logic tx_bit,
   input wire logic tx_valid,
   input wire logic tx_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus phase decode, seen in the same cycle as the request
   wire setup = psel && !penable;
   wire rd_acc = psel && penable && !pwrite;
   wire mapped = paddr inside {tkx_pkg::OFF_CONN, tkx_pkg::OFF_REQ, tkx_pkg::OFF_CONFIRM,
                               tkx_pkg::OFF_STATUS, tkx_pkg::OFF_WRAP};
   wire conf_wr = psel && penable && pready && pwrite && paddr == tkx_pkg::OFF_CONFIRM && pwdata[0];

   a_ready_after_setup: assert property (setup |=> pready)
      else $error("pready missing after setup");
   a_ready_no_stray: assert property (pready |-> $past(setup))
      else $error("pready without setup");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr)
      else $error("no error on unmapped address");
   a_mapped_no_err: assert property (setup && mapped |=> !pslverr)
      else $error("error on mapped address");
   a_prdata_idle: assert property (!rd_acc |-> prdata == 32'h0)
      else $error("read data outside read access");
   a_key_one_cycle: assert property (key_update |=> !key_update)
      else $error("key update longer than one cycle");
   a_tx_after_key: assert property ($rose(key_update) |-> ##2 tx_valid)
      else $error("response did not start in time");
   a_commit_cause: assert property (commit_strobe |-> $past(conf_wr, 2))
      else $error("commit without confirmation");
   a_cookie_commit: assert property (cookie_commit |-> commit_strobe)
      else $error("cookie commit outside commit");
   a_commit_pulse: assert property (commit_strobe |=> !commit_strobe)
      else $error("commit strobe too long");
   a_tx_bit_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_bit))
      else $error("bit changed while sink stalled");

   c_request: cover property (key_update);
   c_commit: cover property (commit_strobe);
   c_cookie: cover property (cookie_commit);
   c_stall: cover property (tx_valid && !tx_ready);
endmodule

// file: tkx_centre_model.sv
`timescale 1ns/1ps
module tkx_centre_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] fld_sel,
   input wire logic [7:0] fld_pos,
   input wire logic tx_bit,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic [7:0] fld_data,
   output logic tx_ready,
   output logic [7:0] msgs,
   output logic [7:0] mlen
);
   logic [7:0] lfsr;
   logic [7:0] sh;
   logic [7:0] nb;
   logic [2:0] bc;
   logic [7:0] buf_q [0:255];
   // each field byte names its field and position, so a misordered field shows up
   assign fld_data = {fld_sel, fld_pos[4:0]};
   // the sink stalls about a quarter of the time to exercise bit holding
   assign tx_ready = lfsr[0] | lfsr[1];
   // bit 7 first into the shifter; a message closes on the last bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr <= 8'h5A;
         bc <= 3'h0;
         nb <= 8'h00;
         msgs <= 8'h00;
         mlen <= 8'h00;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         if (tx_valid && tx_ready) begin
            sh <= {sh[6:0], tx_bit};
            bc <= bc + 3'h1;
            if (bc == 3'h7) begin
               buf_q[nb] <= {sh[6:0], tx_bit};
               nb <= tx_last ? 8'h00 : nb + 8'h01;
            end
            if (tx_last) begin
               mlen <= nb + 8'h01;
               msgs <= msgs + 8'h01;
            end
         end
      end
   end
endmodule

// file: test_terminal_key_exchange_msg_handler.sv
`timescale 1ns/1ps
module test_terminal_key_exchange_msg_handler;
   logic pclk, presetn, psel, penable, pwrite, nv_cookie_seq, nv_counter_seq, rerr;
   logic [7:0] paddr, nonce_len, auth_len, public_value_len, nv_counter, fld_data, fld_pos;
   logic [7:0] commit_counter, msgs, mlen, ecnt, ccnt;
   logic [31:0] pwdata, prdata, rdat, r;
   logic [2:0] fld_sel;
   logic [5:0] key_index;
   logic [1:0] t;
   logic pready, pslverr, commit_strobe, commit_cookie_seq, commit_counter_seq, cookie_gen;
   logic cookie_commit, key_update, key_slot, key_wrapped, tx_bit, tx_valid, tx_last, tx_ready;
   logic ecs, ens, ccs, cns;
   int err_total, comparisons, cyc, gens;

   tkx_handler tkx_handler_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .nonce_len, .auth_len, .public_value_len, .nv_cookie_seq,
      .nv_counter_seq, .nv_counter, .commit_strobe, .commit_cookie_seq, .commit_counter_seq,
      .commit_counter, .cookie_gen, .cookie_commit, .key_update, .key_slot, .key_index,
      .key_wrapped, .fld_sel, .fld_pos, .fld_data, .tx_bit, .tx_valid, .tx_last, .tx_ready);
   tkx_centre_model tkx_centre_model_inst (.pclk, .presetn, .fld_sel, .fld_pos, .tx_bit,
      .tx_valid, .tx_last, .fld_data, .tx_ready, .msgs, .mlen);

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task report_and_stop();
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // a hang is cut short well past the longest expected run
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         report_and_stop();
      end
   end

   // new-cookie pulses, counted so each request can be held against its renew flag
   always @(posedge pclk) if (cookie_gen === 1'b1) gens++;

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task do_reset(input logic cs, input logic ns, input logic [7:0] c);
      nv_cookie_seq <= cs;
      nv_counter_seq <= ns;
      nv_counter <= c;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      {ecs, ens, ecnt} = {cs, ns, c};
      {ccs, cns, ccnt} = {cs, ns, c};
      apb(1'b0, tkx_pkg::OFF_STATUS, 32'h0);
      chk("ready", 32'h1, 32'(rdat[23]));
      chk("loaded state", 32'({c, ns, cs}), 32'(rdat[11:2]));
   endtask

   // expected response byte i, with the pending state already applied
   function automatic logic [7:0] exp_byte(input logic [1:0] mt, input logic [5:0] idx,
         input int i);
      int n, a;
      n = nonce_len;
      a = auth_len;
      if (i < 4) return 8'h00;
      if (i == 4) return {(mt == tkx_pkg::MSG_EXPL) ? idx : 6'h00, ecs, ens};
      if (i == 5) return ecnt;
      if (i < 6 + n) return {3'b001, 5'(i - 6)};
      if (i < 6 + n + a) return {3'b010, 5'(i - 6 - n)};
      return {3'b100, 5'(i - 6 - n - a)};
   endfunction

   task run(input logic [1:0] mt, input logic [7:0] b0, input logic [7:0] b1);
      logic [7:0] fl, nm, len;
      int g0;
      fl = (mt == tkx_pkg::MSG_EXPL) ? b1 : b0;
      if (mt == tkx_pkg::MSG_MAIN && fl[tkx_pkg::FL_RENEW]) begin
         ecs = !ecs;
         ecnt = 8'h00;
         ens = 1'b0;
      end else if (fl[tkx_pkg::FL_BUMP]) begin
         ecnt = ecnt + 8'h01;
         ens = !ens;
      end
      nm = msgs;
      g0 = gens;
      apb(1'b1, tkx_pkg::OFF_REQ, {14'h0, mt, b1, b0});
      while (msgs === nm) @(posedge pclk);
      len = 8'(6 + nonce_len + auth_len + (mt == tkx_pkg::MSG_MAIN ? public_value_len : 8'h00));
      chk("length", 32'(len), 32'(mlen));
      for (int i = 0; i < len; i++) begin
         chk("byte", 32'(exp_byte(mt, b0[7:2], i)),
             32'(tkx_centre_model_inst.buf_q[i]));
      end
      chk("slot", 32'(fl[0]), 32'(key_slot));
      chk("wrapped", 32'(mt == tkx_pkg::MSG_EXPL), 32'(key_wrapped));
      if (mt == tkx_pkg::MSG_EXPL) chk("index", 32'(b0[7:2]), 32'(key_index));
      chk("held", 32'({ccs, cns, ccnt}),
          32'({commit_cookie_seq, commit_counter_seq, commit_counter}));
      do apb(1'b0, tkx_pkg::OFF_STATUS, 32'h0);
      while (rdat[0] !== 1'b0);
      chk("cookie gen", 32'(mt == tkx_pkg::MSG_MAIN && fl[tkx_pkg::FL_RENEW]),
          32'(gens - g0));
      chk("first flag", 32'(mt == tkx_pkg::MSG_MAIN && fl[tkx_pkg::FL_FIRST]),
          32'(rdat[19]));
      chk("reserved flag", 32'(mt == tkx_pkg::MSG_QUICK && b1 != 8'h00),
          32'(rdat[20]));
   endtask

   task confirm();
      apb(1'b1, tkx_pkg::OFF_CONFIRM, 32'h1);
      repeat (4) @(posedge pclk);
      {ccs, cns, ccnt} = {ecs, ens, ecnt};
      chk("committed", 32'({ccs, cns, ccnt}),
          32'({commit_cookie_seq, commit_counter_seq, commit_counter}));
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      nonce_len = 8'h08;
      auth_len = 8'h14;
      public_value_len = 8'h40;
      nv_cookie_seq = 1'b0;
      nv_counter_seq = 1'b0;
      nv_counter = 8'h00;
      void'($urandom(32'hF5E5));
      do_reset(1'b1, 1'b0, 8'h11);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'h1, 32'(rerr));
      chk("unmapped data", 32'h0, rdat);
      run(tkx_pkg::MSG_MAIN, 8'h0F, 8'h00);
      confirm();
      apb(1'b1, tkx_pkg::OFF_WRAP, 32'h1);
      apb(1'b0, tkx_pkg::OFF_WRAP, 32'h0);
      chk("key offset", 32'(2 * nonce_len), 32'(rdat[16:8]));
      apb(1'b1, tkx_pkg::OFF_CONN, 32'h1);
      apb(1'b0, tkx_pkg::OFF_STATUS, 32'h0);
      chk("conn flag", 32'h1, 32'(rdat[22]));
      // counter at its top value wraps to zero; reset then drops the update
      do_reset(1'b0, 1'b1, 8'hFF);
      run(tkx_pkg::MSG_QUICK, 8'h03, 8'h5A);
      do_reset(1'b0, 1'b1, 8'hFF);
      run(tkx_pkg::MSG_EXPL, 8'hA8, 8'h03);
      confirm();
      for (int j = 0; j < 8; j++) begin
         nonce_len <= 8'(1 + $urandom % 8);
         auth_len <= 8'(1 + $urandom % 20);
         public_value_len <= 8'($urandom % 6);
         r = $urandom;
         t = 2'(1 + r[9:8] % 3);
         @(posedge pclk);
         run(t,
             t == tkx_pkg::MSG_MAIN ? {4'h0, r[3:0]} : t == tkx_pkg::MSG_QUICK ?
             {6'h00, r[1:0]} : {r[7:2], 2'b00}, t == tkx_pkg::MSG_EXPL ? {6'h00, r[1:0]} : 8'h00);
         if (r[10]) confirm();
      end
      report_and_stop();
   end
endmodule

bind tkx_handler tkx_handler_asserts tkx_handler_asserts_inst (.pclk, .presetn, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .commit_strobe, .cookie_commit,
   .key_update, .tx_bit, .tx_valid, .tx_ready);
